//--- rspm_defines.vh
// Constants for the reset sequencer and shared reset pin mux
`ifndef RSPM_DEFINES_VH
`define RSPM_DEFINES_VH
// Register indices; byte address is four times the index
`define RSPM_IDX_KEY_LOW    10'h047
`define RSPM_IDX_KEY_HIGH   10'h048
`define RSPM_IDX_STATUS     10'h049
// Reset values and key values
`define RSPM_KEY_RESET      8'h00
`define RSPM_KEY_LOW_VAL    8'h55
`define RSPM_KEY_HIGH_VAL   8'hAA
// Status register fields
`define RSPM_ST_PHASE_LSB   0
`define RSPM_ST_GPIO_BIT    2
`define RSPM_ST_LLOCK_BIT   3
`define RSPM_ST_HLOCK_BIT   4
`define RSPM_ST_CAUSE_LSB   5
// Timing
`define RSPM_CLK_NS         5
`define RSPM_DELAY_CYCLES   7'h40
`define RSPM_WDG_PULSE_NS   100
`define RSPM_WDG_PULSE_CYC  8'h14 // Pulse width in clocks, rounded up
`define RSPM_FETCH_CYCLES   2'h2
// Reset vector
`define RSPM_VEC_LOW_ADDR   16'hFFFE
`define RSPM_VEC_HIGH_ADDR  16'hFFFF
// AXI responses
`define RSPM_RESP_OKAY      2'h0
`define RSPM_RESP_SLVERR    2'h2
`endif

//--- rspm_once_reg.v
// Write-once key register, unlocked by reset events
`default_nettype none
`include "rspm_defines.vh"
module rspm_once_reg (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       clear,
    input  wire       unlock,
    input  wire       we,
    input  wire [7:0] wdata,
    output reg  [7:0] value_q,
    output reg        locked_q
);
    // Internal resets clear, any reset event reopens the one write
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            value_q  <= `RSPM_KEY_RESET;
            locked_q <= 1'b0;
        end else if (we && !locked_q) begin
            // Write beats a same-cycle unlock; it reopens next cycle only if unlock is still high
            value_q  <= wdata;
            locked_q <= 1'b1;
        end else if (unlock) begin
            locked_q <= 1'b0;
        end
    end
endmodule // rspm_once_reg
`default_nettype wire

//--- rspm_cycle_cnt.v
// Loadable down counter for phase lengths
`default_nettype none
module rspm_cycle_cnt #(
    parameter W = 8
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         load,
    input  wire [W-1:0] load_val,
    output wire         busy,
    output wire         last
);
    reg [W-1:0] cnt_q;
    // Load restarts the count; otherwise count down to zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= {W{1'b0}};
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign busy = (cnt_q != {W{1'b0}});
    assign last = (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule // rspm_cycle_cnt
`default_nettype wire

//--- rspm_top.v
// Reset sequencer with write-once pin function keys and AXI4-Lite slave
//
// Overview of operation
// RULE1 - Accept reset from external pin, low-supply detector and watchdog.
// RULE2 - Illegal opcode or illegal prebyte also starts a reset sequence.
// RULE3 - Every source acts on the pin; pin held low throughout delay.
// RULE4 - Reset routine address fetched from vector bytes FFFEh and FFFFh.
// RULE5 - Sequence runs active phase, then delay, then vector fetch.
// RULE6 - Delay phase lasts exactly 64 CPU clock cycles.
// RULE7 - Vector fetch phase takes two clock cycles.
// RULE8 - Pin is input and open-drain output with weak pull-up.
// RULE9 - Low level on external pin enters reset even when halted.
// RULE10 - Pin driven low while supply detector reports low supply.
// RULE11 - Watchdog underflow drives pin low for minimum pulse width.
// RULE12 - Both keys reset to zero; then pin works as reset pin.
// RULE13 - Pin becomes output only with 55h low and AAh high keys.
// RULE14 - Each key takes one write between reset events; reads allowed.
// RULE15 - Software cannot return an output-configured pin to reset.
// RULE16 - Internal resets clear both keys, restoring the reset function.
// RULE17 - Blank memory: outside circuit should hold pin low until programming.
// RULE18 - One key alone, or wrong value, keeps the reset function.
// RULE19 - Delay starts after all sources release; restarts on reassertion.
//
// The implementer's own choice: register access over AXI4-Lite.
`default_nettype none
`include "rspm_defines.vh"
module rspm_top (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Reset sources
    input  wire        low_supply_detector_low,
    input  wire        watchdog_underflow,
    input  wire        illegal_opcode,
    // Shared reset / port pin, three-signal form
    input  wire        shared_pin_in,
    output reg         shared_pin_out,
    output reg         shared_pin_oe,
    input  wire        port_a_line_three_data,
    // Core side
    output reg         core_reset_n,
    output reg         vector_fetch,
    output reg  [15:0] vector_addr
);
    localparam [1:0] ST_ACTIVE = 2'h0;
    localparam [1:0] ST_DELAY  = 2'h1;
    localparam [1:0] ST_FETCH  = 2'h2;
    localparam [1:0] ST_RUN    = 2'h3;
    localparam [7:0] WDG_CYC   = `RSPM_WDG_PULSE_CYC;
    localparam [1:0] FETCH_CYC = `RSPM_FETCH_CYCLES;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [1:0]  fetch_q;
    reg         drive_q;
    reg         pin_mask_q;
    reg  [4:0]  cause_q;
    reg         aw_held_q;
    reg         w_held_q;
    reg  [9:0]  aw_idx_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    wire        gpio_mode;
    wire        ext_low;
    wire        int_event;
    wire        any_req;
    wire        stretch_busy;
    wire        delay_last;
    wire        delay_load;
    wire        wr_fire;
    wire        ar_fire;
    wire        wr_low;
    wire        wr_high;
    wire [7:0]  key_low;
    wire [7:0]  key_high;
    wire        low_locked;
    wire        high_locked;
    wire [9:0]  ar_idx;
    wire        wr_hit;
    wire        rd_hit;
    wire [31:0] status_word;

    // Pin function: output only with both exact keys present
    assign gpio_mode = (key_low == `RSPM_KEY_LOW_VAL) && // RULE13 RULE18
                       (key_high == `RSPM_KEY_HIGH_VAL); // RULE12

    // External request; our own drive is masked, plus one cycle of
    // pull-up recovery, so the device never re-triggers itself
    assign ext_low = !gpio_mode && !shared_pin_in && // RULE1 RULE9
                     !drive_q && !pin_mask_q;

    // Internal events reset the keys and stretch the active phase
    assign int_event = watchdog_underflow || illegal_opcode; // RULE2
    assign any_req   = ext_low || low_supply_detector_low || // RULE1
                       int_event || stretch_busy;

    // Watchdog and illegal opcode pulse stretch to minimum width
    rspm_cycle_cnt #(
        .W (8)
    ) u_stretch (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (int_event), // RULE11
        .load_val (WDG_CYC),
        .busy     (stretch_busy),
        .last     ()
    );

    // Delay counter reloaded on every cycle of the active phase
    assign delay_load = (state_q != ST_DELAY); // RULE19
    rspm_cycle_cnt #(
        .W (7)
    ) u_delay (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (delay_load),
        .load_val (`RSPM_DELAY_CYCLES), // RULE6
        .busy     (),
        .last     (delay_last)
    );

    // Sequencer: any request returns to the active phase
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_ACTIVE: begin
                if (!any_req) begin
                    state_d = ST_DELAY; // RULE5 RULE19
                end
            end
            ST_DELAY: begin
                if (any_req) begin
                    state_d = ST_ACTIVE; // RULE19
                end else if (delay_last) begin
                    state_d = ST_FETCH; // RULE5 RULE6
                end
            end
            ST_FETCH: begin
                if (any_req) begin
                    state_d = ST_ACTIVE;
                end else if (fetch_q == FETCH_CYC - 2'h1) begin
                    state_d = ST_RUN; // RULE7
                end
            end
            ST_RUN: begin
                if (any_req) begin
                    state_d = ST_ACTIVE; // RULE5
                end
            end
            default: begin
                state_d = ST_ACTIVE;
            end
        endcase
    end

    // State, fetch step and vector outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q      <= ST_ACTIVE;
            fetch_q      <= 2'h0;
            core_reset_n <= 1'b0;
            vector_fetch <= 1'b0;
            vector_addr  <= `RSPM_VEC_LOW_ADDR;
        end else begin
            state_q      <= state_d;
            core_reset_n <= (state_d == ST_RUN);
            vector_fetch <= (state_d == ST_FETCH); // RULE7
            if (state_d == ST_FETCH && state_q == ST_FETCH) begin
                fetch_q     <= fetch_q + 2'h1;
                vector_addr <= `RSPM_VEC_HIGH_ADDR; // RULE4
            end else begin
                fetch_q     <= 2'h0;
                vector_addr <= `RSPM_VEC_LOW_ADDR; // RULE4
            end
        end
    end

    // Pin drive: low through active phase of internal sources and delay;
    // registered so the pin never glitches on decode
    always @(posedge aclk) begin
        if (!aresetn) begin
            drive_q        <= 1'b1;
            pin_mask_q     <= 1'b1;
            shared_pin_out <= 1'b0;
            shared_pin_oe  <= 1'b0;
        end else begin
            drive_q <= (state_d == ST_DELAY) || // RULE3
                       low_supply_detector_low || // RULE10
                       int_event || stretch_busy; // RULE11
            pin_mask_q <= drive_q;
            if (gpio_mode) begin
                shared_pin_out <= port_a_line_three_data; // RULE13
                shared_pin_oe  <= 1'b1;
            end else begin
                shared_pin_out <= 1'b0; // RULE8
                shared_pin_oe  <= (state_d == ST_DELAY) || // RULE3
                                  low_supply_detector_low || // RULE10
                                  int_event || stretch_busy; // RULE11
            end
        end
    end

    // Last reset cause: ext, low supply, watchdog, illegal, power-on
    always @(posedge aclk) begin
        if (!aresetn) begin
            cause_q <= 5'h10;
        end else if (ext_low || low_supply_detector_low || int_event) begin
            if (state_q != ST_ACTIVE) begin
                cause_q <= {1'b0, illegal_opcode, watchdog_underflow,
                            low_supply_detector_low, ext_low};
            end else begin
                cause_q <= cause_q | {1'b0, illegal_opcode,
                            watchdog_underflow, low_supply_detector_low,
                            ext_low};
            end
        end
    end

    // AXI write channels accepted independently, held until both arrive
    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign wr_hit        = (aw_idx_q == `RSPM_IDX_KEY_LOW) ||
                           (aw_idx_q == `RSPM_IDX_KEY_HIGH) ||
                           (aw_idx_q == `RSPM_IDX_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_idx_q     <= 10'h000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RSPM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr[11:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RSPM_RESP_OKAY :
                                         `RSPM_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Key writes need byte lane 0; a locked key ignores the write, and
    // output mode refuses all key writes so software cannot undo it
    assign wr_low  = wr_fire && wstrb_q[0] && !gpio_mode && // RULE15
                     (aw_idx_q == `RSPM_IDX_KEY_LOW);
    assign wr_high = wr_fire && wstrb_q[0] && !gpio_mode && // RULE15
                     (aw_idx_q == `RSPM_IDX_KEY_HIGH);

    // Keys: internal events clear, any reset event reopens the write
    rspm_once_reg u_key_low (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (int_event || low_supply_detector_low), // RULE16
        .unlock   (ext_low), // RULE14
        .we       (wr_low), // RULE14 RULE15
        .wdata    (wdata_q[7:0]),
        .value_q  (key_low),
        .locked_q (low_locked)
    );
    rspm_once_reg u_key_high (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (int_event || low_supply_detector_low), // RULE16
        .unlock   (ext_low), // RULE14
        .we       (wr_high), // RULE14 RULE15
        .wdata    (wdata_q[7:0]),
        .value_q  (key_high),
        .locked_q (high_locked)
    );

    // Status word: phase, pin mode, key locks, last cause
    assign status_word = {22'h000000, cause_q, high_locked, low_locked,
                          gpio_mode, state_q};

    // Read channel: one outstanding read, answered the next cycle
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign ar_idx        = s_axi_araddr[11:2];
    assign rd_hit        = (ar_idx == `RSPM_IDX_KEY_LOW) ||
                           (ar_idx == `RSPM_IDX_KEY_HIGH) ||
                           (ar_idx == `RSPM_IDX_STATUS);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RSPM_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_hit ? `RSPM_RESP_OKAY : `RSPM_RESP_SLVERR;
            case (ar_idx)
                `RSPM_IDX_KEY_LOW: begin
                    s_axi_rdata <= {24'h000000, key_low}; // RULE14
                end
                `RSPM_IDX_KEY_HIGH: begin
                    s_axi_rdata <= {24'h000000, key_high}; // RULE14
                end
                `RSPM_IDX_STATUS: begin
                    s_axi_rdata <= status_word;
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // rspm_top
`default_nettype wire

//--- rspm_pin_model.sv
// Outside reset circuitry and weak pull-up on the shared reset pin
`default_nettype none
module rspm_pin_model (
    input  wire logic pin_oe,
    input  wire logic pin_out,
    input  wire logic ext_pull_low,
    output wire logic pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device drive wins; else the outside pull-down; else the weak pull-up
    assign pin_level = pin_oe ? pin_out : !ext_pull_low;
endmodule // rspm_pin_model
`default_nettype wire

//--- rspm_top_checker.sv
// Concurrent checks on the reset sequencer ports
`default_nettype none
module rspm_top_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        low_supply_detector_low,
    input wire logic        watchdog_underflow,
    input wire logic        illegal_opcode,
    input wire logic        shared_pin_in,
    input wire logic        shared_pin_out,
    input wire logic        shared_pin_oe,
    input wire logic        core_reset_n,
    input wire logic        vector_fetch,
    input wire logic [15:0] vector_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic       pin_low;
    logic [6:0] low_cnt_q, low_cnt_d;
    // Run of cycles with the pin driven low; saturates so long holds pass
    assign pin_low = shared_pin_oe && !shared_pin_out;
    assign low_cnt_d = !pin_low ? 7'h0 :
                       (low_cnt_q == 7'h7F) ? low_cnt_q : low_cnt_q + 7'h1;
    always_ff @(posedge aclk) begin
        low_cnt_q <= aresetn ? low_cnt_d : 7'h0;
    end
    fetch_len_a: assert property ($rose(vector_fetch) |=>
        vector_fetch ##1 !vector_fetch) else $error("fetch not two cycles");
    fetch_addr_a: assert property ($rose(vector_fetch) |->
        vector_addr == 16'hFFFE ##1 vector_addr == 16'hFFFF)
        else $error("wrong vector address");
    delay_low_a: assert property ($rose(vector_fetch) |->
        low_cnt_q >= 7'h40) else $error("pin not low through delay");
    run_after_a: assert property ($fell(vector_fetch) |->
        core_reset_n && !shared_pin_oe) else $error("no run after fetch");
    core_held_a: assert property ((low_supply_detector_low ||
        illegal_opcode) |-> ##[1:2] !core_reset_n)
        else $error("core not held in reset");
    supply_pin_a: assert property (low_supply_detector_low [*4] |->
        pin_low) else $error("pin not low on low supply");
    wdg_pulse_a: assert property (watchdog_underflow |->
        ##[1:3] pin_low [*8]) else $error("watchdog pulse too short");
    ext_pin_a: assert property ((!shared_pin_in && !shared_pin_oe &&
        core_reset_n) |-> ##[1:4] !core_reset_n)
        else $error("external reset missed");
    cover property ($rose(vector_fetch));
    cover property (watchdog_underflow);
    cover property ($rose(shared_pin_oe) && core_reset_n);
endmodule // rspm_top_checker
bind rspm_top rspm_top_checker rspm_top_checker_inst (.aclk, .aresetn,
    .low_supply_detector_low, .watchdog_underflow, .illegal_opcode,
    .shared_pin_in, .shared_pin_out, .shared_pin_oe, .core_reset_n,
    .vector_fetch, .vector_addr);
`default_nettype wire

//--- test_reset_sequence_and_pin_mux.sv
// Self-checking testbench for the reset sequencer and pin mux
`default_nettype none
`include "rspm_defines.vh"
module test_reset_sequence_and_pin_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, shared_pin_out;
    logic        shared_pin_oe, port_a_line_three_data, core_reset_n;
    logic        vector_fetch, ext_low, pin_level;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  src;
    logic [15:0] vector_addr;
    logic [1:0]  wq[$];
    logic [33:0] rq[$];
    int          n_fail, cmp_count, cnt, waited;

    rspm_top rspm_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .low_supply_detector_low(src[0]), .watchdog_underflow(src[1]),
        .illegal_opcode(src[2]), .shared_pin_in(pin_level), .shared_pin_out,
        .shared_pin_oe, .port_a_line_three_data, .core_reset_n,
        .vector_fetch, .vector_addr);
    rspm_pin_model rspm_pin_model_inst (.pin_oe(shared_pin_oe),
        .pin_out(shared_pin_out), .ext_pull_low(ext_low),
        .pin_level(pin_level));

    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Write one key byte; upper data bits random since they are ignored
    task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] r);
        wq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= ($urandom() & 32'hFFFFFF00) | {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] d,
                      input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
    endtask

    // Responses are taken off the note queues in arrival order
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready)
            check(34'(s_axi_bresp), 34'(wq.pop_front()));
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end

    // Follow one sequence to its end; counts the low-drive run before fetch
    task automatic run_seq(input bit exact);
        cnt = 0;
        waited = 0;
        forever begin
            @(posedge aclk);
            if (vector_fetch === 1'h1 || waited > 3000) break;
            waited++;
            cnt = (shared_pin_oe === 1'h1 && shared_pin_out === 1'h0) ?
                  cnt + 1 : 0;
        end
        if (exact) check(34'(cnt), 34'h40);
        else check(34'(cnt >= 64), 34'h1);
        check(34'(vector_addr), 34'hFFFE);
        @(posedge aclk);
        check({vector_fetch, vector_addr}, {1'h1, 16'hFFFF});
        @(posedge aclk);
        check({vector_fetch, core_reset_n}, 2'h1);
    endtask

    task automatic fire(input int s, input int len);
        @(posedge aclk);
        src <= 3'h1 << s;
        repeat (len) @(posedge aclk);
        src <= 3'h0;
    endtask

    initial begin
        #100us;
        n_fail++;
        results();
    end

    initial begin
        void'($urandom(22131));
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, port_a_line_three_data} = 3'h0;
        {src, ext_low, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        run_seq(1);
        // Status after power-on: cause por, no locks, reset pin, run phase
        rd(`RSPM_IDX_STATUS, 32'h00000203, `RSPM_RESP_OKAY);
        rd(`RSPM_IDX_KEY_LOW, 8'h00, `RSPM_RESP_OKAY);
        rd(`RSPM_IDX_KEY_HIGH, 8'h00, `RSPM_RESP_OKAY);
        rd(10'h050, 8'h00, `RSPM_RESP_SLVERR);
        wr(10'h050, 8'h55, `RSPM_RESP_SLVERR);
        wr(`RSPM_IDX_KEY_LOW, 8'h55, `RSPM_RESP_OKAY);
        wr(`RSPM_IDX_KEY_HIGH, 8'h3C, `RSPM_RESP_OKAY);
        wr(`RSPM_IDX_KEY_HIGH, 8'hAA, `RSPM_RESP_OKAY);
        rd(`RSPM_IDX_KEY_HIGH, 8'h3C, `RSPM_RESP_OKAY);
        check(34'(shared_pin_oe), 34'h0);
        // Outside pull-down in run mode reopens the one write
        @(posedge aclk) ext_low <= 1'h1;
        repeat (6) @(posedge aclk);
        ext_low <= 1'h0;
        run_seq(0);
        rd(`RSPM_IDX_KEY_HIGH, 8'h3C, `RSPM_RESP_OKAY);
        wr(`RSPM_IDX_KEY_HIGH, 8'hAA, `RSPM_RESP_OKAY);
        rd(`RSPM_IDX_KEY_HIGH, 8'hAA, `RSPM_RESP_OKAY);
        // Cause ext, high key locked, low key reopened, output mode, run
        rd(`RSPM_IDX_STATUS, 32'h00000037, `RSPM_RESP_OKAY);
        repeat (8) begin
            @(posedge aclk) port_a_line_three_data <= 1'($urandom());
            repeat (3) @(posedge aclk);
            check({shared_pin_oe, shared_pin_out},
                  {1'h1, port_a_line_three_data});
        end
        // Software and the pin can no longer undo output mode
        wr(`RSPM_IDX_KEY_LOW, 8'h00, `RSPM_RESP_OKAY);
        @(posedge aclk) ext_low <= 1'h1;
        repeat (6) @(posedge aclk);
        ext_low <= 1'h0;
        check({shared_pin_oe, core_reset_n}, 2'h3);
        for (int s = 0; s < 3; s++) begin
            if (s > 0) begin
                wr(`RSPM_IDX_KEY_LOW, 8'h55, `RSPM_RESP_OKAY);
                wr(`RSPM_IDX_KEY_HIGH, 8'hAA, `RSPM_RESP_OKAY);
                repeat (3) @(posedge aclk);
            end
            check(34'(shared_pin_oe), 34'h1);
            fire(s, (s == 0) ? 10 + $urandom_range(9) : 1);
            run_seq(0);
            rd(`RSPM_IDX_KEY_LOW, 8'h00, `RSPM_RESP_OKAY);
            rd(`RSPM_IDX_KEY_HIGH, 8'h00, `RSPM_RESP_OKAY);
            check(34'(shared_pin_oe), 34'h0);
        end
        // Second request inside the delay must restart the full count
        fire(0, 5);
        repeat (30) @(posedge aclk);
        fire(2, 1);
        run_seq(0);
        check(34'(waited >= 64), 34'h1);
        results();
    end
endmodule // test_reset_sequence_and_pin_mux
`default_nettype wire
